// ===== hw/cpw_top.sv
// processor control registers: bank base, revision, clock divider, power and wake
// assumes one 25 MHz clock; wake inputs are asynchronous pins, irq_any is same-clock
module cpw_top import cpw_pkg::*; #(
  parameter logic [15:0] REVISION = CPW_REV_DEFAULT,
  parameter int RESUME_CYC = CPW_RESUME_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // axi4-lite slave
  input wire logic [15:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [15:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // general register address formation
  input wire logic [3:0] GREG_NUM,
  output logic [15:0] GREG_ADDR,
  // wake sources and boost status (asynchronous pins)
  input wire logic [3:0] USB_LINE,
  input wire logic OTG_VBUS_VALID,
  input wire logic OTG_ID,
  input wire logic SER_RX,
  input wire logic SPI_SELECT_LOW,
  input wire logic HOST_READ,
  input wire logic [1:0] GPIO_WAKE,
  input wire logic BOOST_LOW,
  // enabled interrupt from the interrupt logic
  input wire logic IRQ_ANY,
  // processor control
  output logic CPU_CLK_EN,
  output logic CPU_RUN,
  output logic CLK_STOPPED,
  output logic USB_WAKE,
  output logic OTG_WAKE_IRQ
);
  typedef enum logic [3:0] {
    CPW_RUN = 4'h1, CPW_HALT = 4'h2, CPW_SLEEP = 4'h4, CPW_RESUME = 4'h8
  } cpw_mode_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [11:0] pin_s1;
    logic [11:0] pin_s2;
    logic [11:0] pin_old;
    logic [15:0] base;
    logic [3:0] speed;
    logic [3:0] speed_act;
    logic [3:0] div_cnt;
    logic [15:0] wake_en;
    cpw_mode_t mode;
    logic [31:0] resume_cnt;
    logic aw_hold;
    logic [15:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] greg_addr;
    logic cpu_en;
    logic usb_wake;
    logic otg_irq;
  } cpw_state_t;

  cpw_state_t q, d;
  logic rst_n;
  assign rst_n = q.rst_sync[1];

  function automatic logic [15:0] cpw_wmerge(logic [15:0] old, logic [31:0] wd,
                                             logic [3:0] st);
    cpw_wmerge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic cpw_known(logic [15:0] a);
    cpw_known = (a == CPW_OFF_BASE) || (a == CPW_OFF_REV) ||
                (a == CPW_OFF_SPEED) || (a == CPW_OFF_POWER);
  endfunction

  logic [15:0] power_view;
  logic [11:0] pin_now;
  logic [11:0] pin_chg;
  logic usb_ev, other_ev, do_wr;
  logic [15:0] wr_val;

  always_comb begin
    d = q;
    d.rst_sync = {q.rst_sync[0], 1'b1};
    pin_now = {BOOST_LOW, GPIO_WAKE, HOST_READ, SPI_SELECT_LOW, SER_RX, OTG_ID,
               OTG_VBUS_VALID, USB_LINE};
    d.pin_s1 = pin_now;
    d.pin_s2 = q.pin_s1;
    d.pin_old = q.pin_s2;
    pin_chg = q.pin_s2 ^ q.pin_old;
    power_view = q.wake_en & CPW_WAKE_MASK;
    power_view[CPW_B_BOOST] = q.pin_s2[11];
    power_view[CPW_B_SLEEP] = (q.mode == CPW_SLEEP);
    power_view[CPW_B_HALT] = (q.mode == CPW_HALT);
    usb_ev = |(pin_chg[3:0] & q.wake_en[15:12]);
    other_ev = (pin_chg[4] | pin_chg[5]) & q.wake_en[CPW_B_OTG];
    other_ev = other_ev | (pin_chg[6] & q.wake_en[CPW_B_SER]);
    other_ev = other_ev | (pin_chg[7] & ~q.pin_s2[7] & q.wake_en[CPW_B_SPI]);
    other_ev = other_ev | (pin_chg[8] & q.pin_s2[8] & q.wake_en[CPW_B_HOST]);
    other_ev = other_ev | (|pin_chg[10:9] & q.wake_en[CPW_B_GPIO]);
    d.usb_wake = 1'b0;
    d.otg_irq = 1'b0;
    // write channel: accept address and data independently
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      d.aw_hold = 1'b1;
      d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      d.w_hold = 1'b1;
      d.w_data = S_AXI_WDATA;
      d.w_strb = S_AXI_WSTRB;
    end
    do_wr = q.aw_hold && q.w_hold && !q.bvalid;
    wr_val = 16'h0000;
    if (do_wr) begin
      d.aw_hold = 1'b0;
      d.w_hold = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = cpw_known(q.aw_addr) ? CPW_RESP_OK : CPW_RESP_ERR;
      if (q.aw_addr == CPW_OFF_BASE) begin
        d.base = cpw_wmerge(q.base, q.w_data, q.w_strb) & CPW_BASE_MASK;
      end
      if (q.aw_addr == CPW_OFF_SPEED) begin
        wr_val = cpw_wmerge({12'h000, q.speed}, q.w_data, q.w_strb);
        d.speed = wr_val[3:0];
      end
      if (q.aw_addr == CPW_OFF_POWER) begin
        wr_val = cpw_wmerge(power_view, q.w_data, q.w_strb);
        d.wake_en = wr_val & CPW_WAKE_MASK;
        if (q.mode == CPW_RUN && wr_val[CPW_B_SLEEP]) begin
          d.mode = CPW_SLEEP;
        end else if (q.mode == CPW_RUN && wr_val[CPW_B_HALT]) begin
          d.mode = CPW_HALT;
        end
      end
      // revision writes fall through with no effect
    end
    if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      d.rvalid = 1'b1;
      d.rresp = cpw_known(S_AXI_ARADDR) ? CPW_RESP_OK : CPW_RESP_ERR;
      unique case (S_AXI_ARADDR)
        CPW_OFF_BASE: d.rdata = {16'h0000, q.base};
        CPW_OFF_REV: d.rdata = {16'h0000, REVISION};
        CPW_OFF_SPEED: d.rdata = {28'h0000000, q.speed};
        CPW_OFF_POWER: d.rdata = {16'h0000, power_view};
        default: d.rdata = 32'h00000000;
      endcase
    end else if (q.rvalid && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
    // power mode sequencing
    unique case (q.mode)
      CPW_RUN: ;
      CPW_HALT: if (IRQ_ANY) d.mode = CPW_RUN;
      CPW_SLEEP: begin
        if (usb_ev || other_ev) begin
          d.mode = CPW_RESUME;
          d.resume_cnt = 32'(RESUME_CYC - 1);
          d.usb_wake = usb_ev;
          d.otg_irq = (pin_chg[4] | pin_chg[5]) & q.wake_en[CPW_B_OTG];
        end
      end
      CPW_RESUME: begin
        if (q.resume_cnt == 32'd0) d.mode = CPW_RUN;
        else d.resume_cnt = q.resume_cnt - 32'd1;
      end
      default: d.mode = CPW_RUN;
    endcase
    // processor enable divider: peripherals keep CLK undivided
    d.cpu_en = 1'b0;
    if (q.mode == CPW_RUN) begin
      if (q.div_cnt >= q.speed_act) begin
        d.div_cnt = 4'h0;
        d.cpu_en = 1'b1;
        d.speed_act = q.speed;
      end else begin
        d.div_cnt = q.div_cnt + 4'h1;
      end
    end
    d.greg_addr = (q.base & CPW_BASE_MASK) | {11'h000, GREG_NUM, 1'b0};
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
      q.base <= CPW_BASE_RST;
      q.speed <= CPW_SPEED_RST;
      q.speed_act <= CPW_SPEED_RST;
      q.mode <= CPW_RUN;
    end else if (!rst_n) begin
      q <= '0;
      q.rst_sync <= {q.rst_sync[0], 1'b1};
      q.base <= CPW_BASE_RST;
      q.speed <= CPW_SPEED_RST;
      q.speed_act <= CPW_SPEED_RST;
      q.mode <= CPW_RUN;
    end else begin
      q <= d;
    end
  end

  assign S_AXI_AWREADY = rst_n && !q.aw_hold;
  assign S_AXI_WREADY = rst_n && !q.w_hold;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = rst_n && !q.rvalid;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign GREG_ADDR = q.greg_addr;
  assign CPU_CLK_EN = q.cpu_en;
  assign CPU_RUN = (q.mode == CPW_RUN);
  assign CLK_STOPPED = (q.mode == CPW_SLEEP);
  assign USB_WAKE = q.usb_wake;
  assign OTG_WAKE_IRQ = q.otg_irq;

  AST_BASE_RESET: assert property (@(posedge CLK)
    $rose(rst_n) |-> q.base == CPW_BASE_RST)
    else $error("bank base not at reset value");
  AST_GREG_ADDR: assert property (@(posedge CLK) disable iff (!rst_n)
    1'b1 |=> GREG_ADDR == ({$past(q.base[15:4]), 4'h0} | {11'h000, $past(GREG_NUM), 1'b0}))
    else $error("general register address wrong");
  AST_BASE_WRITE: assert property (@(posedge CLK) disable iff (!rst_n)
    do_wr && q.aw_addr == CPW_OFF_BASE && q.w_strb[1:0] == 2'h3
    |=> q.base == {$past(q.w_data[15:4]), 4'h0})
    else $error("bank base write wrong");
  AST_REV_CONST: assert property (@(posedge CLK) disable iff (!rst_n)
    S_AXI_RVALID && $past(S_AXI_ARADDR) == CPW_OFF_REV && $rose(S_AXI_RVALID)
    |-> S_AXI_RDATA[15:0] == REVISION)
    else $error("revision read wrong");
  AST_DIV_PERIOD: assert property (@(posedge CLK) disable iff (!rst_n)
    CPU_CLK_EN && q.speed_act == 4'h1 && q.mode == CPW_RUN ##1 q.mode == CPW_RUN
    |-> !CPU_CLK_EN)
    else $error("divider period too short");
  AST_DIV_NOSTRETCH: assert property (@(posedge CLK) disable iff (!rst_n)
    !q.cpu_en && !$past(q.cpu_en) |-> $stable(q.speed_act))
    else $error("divisor changed mid period");
  AST_WAKE_EN_WRITE: assert property (@(posedge CLK) disable iff (!rst_n)
    do_wr && q.aw_addr == CPW_OFF_POWER && q.w_strb[1:0] == 2'h3
    |=> q.wake_en == ($past(q.w_data[15:0]) & CPW_WAKE_MASK))
    else $error("wake enables written wrong");
  AST_SLEEP_ENTRY: assert property (@(posedge CLK) disable iff (!rst_n)
    do_wr && q.aw_addr == CPW_OFF_POWER && q.w_strb[0] && q.w_data[CPW_B_SLEEP] &&
    q.mode == CPW_RUN |=> q.mode == CPW_SLEEP)
    else $error("sleep request not taken");
  AST_NO_CPU_SLEEP: assert property (@(posedge CLK) disable iff (!rst_n)
    q.mode == CPW_SLEEP |=> !CPU_CLK_EN)
    else $error("processor clocked while asleep");
  AST_RESUME_BOUND: assert property (@(posedge CLK) disable iff (!rst_n)
    q.mode == CPW_RESUME |-> q.resume_cnt < 32'(RESUME_CYC))
    else $error("resume delay too long");
  AST_HALT_EXIT: assert property (@(posedge CLK) disable iff (!rst_n)
    q.mode == CPW_HALT && IRQ_ANY |=> q.mode == CPW_RUN)
    else $error("halt not ended by interrupt");
  AST_HALT_NO_CPU: assert property (@(posedge CLK) disable iff (!rst_n)
    q.mode == CPW_HALT |=> !CPU_CLK_EN)
    else $error("processor clocked while halted");
  AST_USB_NOIRQ: assert property (@(posedge CLK) disable iff (!rst_n)
    USB_WAKE && !$past(other_ev) |-> !OTG_WAKE_IRQ)
    else $error("usb wake raised interrupt");
  AST_WAKE_USB: assert property (@(posedge CLK) disable iff (!rst_n)
    q.mode == CPW_SLEEP && usb_ev |=> q.mode == CPW_RESUME && USB_WAKE)
    else $error("usb wake missed");
  AST_WAKE_OTG: assert property (@(posedge CLK) disable iff (!rst_n)
    q.mode == CPW_SLEEP && q.wake_en[CPW_B_OTG] && q.pin_s2[5:4] != q.pin_old[5:4]
    |=> q.mode == CPW_RESUME && OTG_WAKE_IRQ)
    else $error("otg wake missed");
  AST_WAKE_SER: assert property (@(posedge CLK) disable iff (!rst_n)
    q.mode == CPW_SLEEP && q.wake_en[CPW_B_SER] && q.pin_s2[6] != q.pin_old[6]
    |=> q.mode == CPW_RESUME)
    else $error("serial wake missed");
  AST_WAKE_SPI: assert property (@(posedge CLK) disable iff (!rst_n)
    q.mode == CPW_SLEEP && q.wake_en[CPW_B_SPI] && q.pin_old[7] && !q.pin_s2[7]
    |=> q.mode == CPW_RESUME)
    else $error("select wake missed");
  AST_WAKE_HOST: assert property (@(posedge CLK) disable iff (!rst_n)
    q.mode == CPW_SLEEP && q.wake_en[CPW_B_HOST] && q.pin_s2[8] && !q.pin_old[8]
    |=> q.mode == CPW_RESUME)
    else $error("host port wake missed");
  AST_WAKE_GPIO: assert property (@(posedge CLK) disable iff (!rst_n)
    q.mode == CPW_SLEEP && q.wake_en[CPW_B_GPIO] && q.pin_s2[10:9] != q.pin_old[10:9]
    |=> q.mode == CPW_RESUME)
    else $error("pin wake missed");
  AST_BOOST_READ: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(S_AXI_RVALID) && $past(S_AXI_ARADDR) == CPW_OFF_POWER
    |-> S_AXI_RDATA[CPW_B_BOOST] == $past(q.pin_s2[11]))
    else $error("boost status read wrong");
endmodule

// ===== shared/cpw_pkg.sv
// constants, register map and field layout of the processor control group
// assumes a 32-bit axi4-lite slave with byte addresses taken from the register map
// Functional notes
// - bank base resets to 0x0100
// - ram address = base or reg<<1, bit0 low
// - read-only sixteen-bit silicon revision, writes ignored
// - processor clock is system rate over N+1
// - divider slows processor only, peripherals undivided
// - sleep or halt request, others wake enables
// - bits 15..12 arm usb port wakeups
// - usb port wakeup raises no processor interrupt
// - bit 11 wakes on otg vbus/id change
// - bit 9 wakes on fast serial rx transition
// - bit 8 wakes on select falling edge
// - waking serial or spi byte is lost
// - bit 7 wakes on host port read
// - bit 4 wakes on gpio 25/24 transition
// - bit 2 reports boost rails below 3.0V
// - bit 1 sleeps; enabled wake resumes within 0.5ms
// - bit 0 halts processor; enabled interrupt ends
package cpw_pkg;
  localparam logic [15:0] CPW_OFF_BASE = 16'hc002;
  localparam logic [15:0] CPW_OFF_REV = 16'hc004;
  localparam logic [15:0] CPW_OFF_SPEED = 16'hc008;
  localparam logic [15:0] CPW_OFF_POWER = 16'hc00a;
  localparam logic [15:0] CPW_BASE_RST = 16'h0100;
  localparam logic [15:0] CPW_BASE_MASK = 16'hfff0;
  localparam logic [3:0] CPW_SPEED_RST = 4'hf;
  localparam logic [15:0] CPW_WAKE_MASK = 16'hfb90;
  localparam int CPW_B_HALT = 0;
  localparam int CPW_B_SLEEP = 1;
  localparam int CPW_B_BOOST = 2;
  localparam int CPW_B_GPIO = 4;
  localparam int CPW_B_HOST = 7;
  localparam int CPW_B_SPI = 8;
  localparam int CPW_B_SER = 9;
  localparam int CPW_B_OTG = 11;
  localparam int CPW_B_USB = 12;
  localparam logic [1:0] CPW_RESP_OK = 2'h0;
  localparam logic [1:0] CPW_RESP_ERR = 2'h2;
  // resume delay after wake, in microseconds, and in clocks at 25 MHz
  localparam int CPW_CLK_MHZ = 25;
  localparam int CPW_RESUME_US = 500;
  localparam int CPW_RESUME_CYC = CPW_RESUME_US * CPW_CLK_MHZ;
  // arbitrary neutral revision value
  localparam logic [15:0] CPW_REV_DEFAULT = 16'h0a00;
endpackage

// ===== testbench/cpw_cpu_model.sv
// processor-side model: times the spacing of processor clock enables
// assumes the block's system clock and its registered enable pulse
module cpw_cpu_model (
  // clock
  input wire logic clk,
  // processor clock enable from the block
  input wire logic cpu_clk_en,
  // last measured spacing in system clocks
  output int gap
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // the core advances only on enables, peripherals keep the system clock
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (cpu_clk_en) begin
      gap <= cnt + 1;
      cnt <= 0;
    end
  end
endmodule

// ===== testbench/cpu_control_power_wake_bench.sv
// self-checking bench for the processor control group over axi4-lite
// assumes cpw_top, cpw_pkg and the processor model are compiled first
module cpu_control_power_wake_bench import cpw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, ser = 0, spi = 1;
  logic host = 0, vb = 0, id = 0, bst = 0, irq = 0;
  logic awr, wrdy, bv, arr, rv, cen, run, stp, uw, ow;
  logic [15:0] awa = 0, ara = 0, gaddr, v;
  logic [31:0] wd = 0, rd, lf = 32'h9955;
  logic [3:0] gn = 4'he, usb = 0;
  logic [1:0] gp = 0, br, rr;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int fail_count = 0, num_checks = 0, gap, k;
  int uw_n = 0, ow_n = 0, uw0 = 0, ow0 = 0;
  int eb[9] = '{12, 13, 14, 15, 11, 9, 8, 7, 4};
  int sp[4] = '{0, 1, 3, 15};

  cpw_top #(.RESUME_CYC(8)) uut (.CLK(clk), .RESETN(rstn), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h3),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .GREG_NUM(gn), .GREG_ADDR(gaddr), .USB_LINE(usb), .OTG_VBUS_VALID(vb), .OTG_ID(id),
    .SER_RX(ser), .SPI_SELECT_LOW(spi), .HOST_READ(host), .GPIO_WAKE(gp), .BOOST_LOW(bst),
    .IRQ_ANY(irq), .CPU_CLK_EN(cen), .CPU_RUN(run), .CLK_STOPPED(stp), .USB_WAKE(uw),
    .OTG_WAKE_IRQ(ow));
  cpw_cpu_model cpu (.clk(clk), .cpu_clk_en(cen), .gap(gap));

  initial begin
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic tmo(input bit b);
    if (b) begin
      fail_count++;
      finish_test();
    end
  endtask

  // results are compared in order of arrival against the queued notes
  always @(posedge clk) begin
    if (rv && rre) chk("read", rq.pop_front(), {rr, rd});
    if (bv && bre) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, br});
    if (uw) uw_n <= uw_n + 1;
    if (ow) ow_n <= ow_n + 1;
  end

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] r);
    int n;
    @(posedge clk);
    bq.push_back(r);
    awa <= a;
    wd <= {16'h0, d};
    awv <= 1;
    wv <= 1;
    bre <= 1;
    n = 0;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
      n++;
    end while (!(bv && bre) && n < 60);
    bre <= 0;
    tmo(n >= 60);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge clk);
    rq.push_back({r, d});
    ara <= a;
    arv <= 1;
    rre <= 1;
    n = 0;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
      n++;
    end while (!(rv && rre) && n < 60);
    rre <= 0;
    tmo(n >= 60);
  endtask

  // waits for run (k=1) or stopped (k=0) to reach level l
  task automatic wt(input int k, input logic l);
    int n;
    for (n = 0; n < 200 && (k ? run : stp) !== l; n++) @(posedge clk);
    tmo(n >= 200);
  endtask

  task automatic kick(input int s);
    @(posedge clk);
    case (s)
      0, 1, 2, 3: usb[s] <= !usb[s];
      4: id <= !id;
      5: ser <= !ser;
      6: spi <= 0;
      7: host <= 1;
      default: gp[0] <= !gp[0];
    endcase
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1;
    repeat (4) @(posedge clk);
    chk("gaddr", 16'h011c, gaddr);
    rdc(CPW_OFF_BASE, 32'h0100, CPW_RESP_OK);
    rdc(CPW_OFF_REV, CPW_REV_DEFAULT, CPW_RESP_OK);
    rdc(CPW_OFF_SPEED, 32'hf, CPW_RESP_OK);
    rdc(CPW_OFF_POWER, 32'h0, CPW_RESP_OK);
    wr(CPW_OFF_REV, 16'h1234, CPW_RESP_OK);
    rdc(CPW_OFF_REV, CPW_REV_DEFAULT, CPW_RESP_OK);
    wr(16'hc006, 16'hffff, CPW_RESP_ERR);
    rdc(16'hc006, 32'h0, CPW_RESP_ERR);
    for (k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      v = lf[15:0] & 16'hfff0;
      wr(CPW_OFF_BASE, v, CPW_RESP_OK);
      rdc(CPW_OFF_BASE, {16'h0, v}, CPW_RESP_OK);
      gn <= lf[19:16];
      repeat (3) @(posedge clk);
      chk("gaddr", v | {11'h0, lf[19:16], 1'b0}, gaddr);
    end
    for (k = 0; k < 4; k++) begin
      wr(CPW_OFF_SPEED, sp[k], CPW_RESP_OK);
      rdc(CPW_OFF_SPEED, sp[k], CPW_RESP_OK);
      repeat (40) @(posedge clk);
      chk("gap", sp[k] + 1, gap);
    end
    bst <= 1;
    repeat (5) @(posedge clk);
    wr(CPW_OFF_POWER, 16'h0001, CPW_RESP_OK);
    rdc(CPW_OFF_POWER, 32'h5, CPW_RESP_OK);
    chk("halt", 0, run);
    irq <= 1;
    @(posedge clk);
    irq <= 0;
    wt(1, 1);
    for (k = 0; k < 9; k++) begin
      uw0 = uw_n;
      ow0 = ow_n;
      wr(CPW_OFF_POWER, 16'h0002 | (16'h1 << eb[k]), CPW_RESP_OK);
      wt(0, 1);
      if (k == 0) begin
        kick(5);
        repeat (30) @(posedge clk);
        chk("asleep", 1, stp);
      end
      kick(k);
      wt(1, 1);
      repeat (3) @(posedge clk);
      chk("usbwake", k < 4, uw_n != uw0);
      chk("otgwake", k == 4, ow_n != ow0);
      spi <= 1;
      host <= 0;
    end
    finish_test();
  end
endmodule
